// ### core/ipcr_pkg.sv
// Shared constants and types for the two-wire port control block
package ipcr_pkg;

	// System clock rate
	localparam int CLK_HZ = 20_000_000;

	// Register indices on the local bus
	localparam logic [2:0] ADDR_CTRL_PRIMARY = 3'h0;
	localparam logic [2:0] ADDR_CTRL_SECONDARY = 3'h1;
	localparam logic [2:0] ADDR_TRANSFER_BUFFER = 3'h2;
	localparam logic [2:0] ADDR_RELOAD = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h4;
	localparam logic [2:0] ADDR_GPIO = 3'h5;

	// Values after reset
	localparam logic [7:0] CTRL_PRIMARY_RESET = 8'h00;
	localparam logic [7:0] CTRL_SECONDARY_RESET = 8'h00;
	localparam logic [7:0] BUFFER_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [1:0] GPIO_RESET = 2'h0;

	// Status register bit positions
	localparam int ST_BUFFER_FULL = 0;
	localparam int ST_ADDR_UPDATE = 1;
	localparam int ST_READ_WRITE = 2;
	localparam int ST_START_SEEN = 3;
	localparam int ST_STOP_SEEN = 4;
	localparam int ST_PORT_EVENT = 5;

	// GPIO register field positions
	localparam int GPIO_OUT_LSB = 0;
	localparam int GPIO_DIR_LSB = 2;
	localparam int GPIO_IN_LSB = 4;

	// Mode select encodings
	localparam logic [3:0] MODE_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_SLAVE10 = 4'h7;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_FW_MASTER = 4'hB;
	localparam logic [3:0] MODE_SLAVE7_EVT = 4'hE;
	localparam logic [3:0] MODE_SLAVE10_EVT = 4'hF;

	// Address constants and bit counts
	localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam logic [1:0] QUARTER_LAST = 2'h3;

	// First control register layout
	typedef struct packed {
		logic write_collision_flag;
		logic receive_overflow_flag;
		logic port_enable_bit;
		logic clock_release_bit;
		logic [3:0] mode_select_field;
	} ipcr_ctrl_primary_t;

	// Second control register layout
	typedef struct packed {
		logic general_call_enable;
		logic ack_received_status;
		logic ack_data_value;
		logic ack_sequence_request;
		logic master_receive_request;
		logic stop_request;
		logic repeated_start_request;
		logic start_or_stretch_bit;
	} ipcr_ctrl_secondary_t;

endpackage

// ### core/ipcr_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage pin synchroniser with agreement filter
module ipcr_pin_sync #(
	parameter logic IDLE = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Raw pin and filtered level
	input wire logic pin_i,
	output logic level_o
);

	logic meta_reg, mid_reg, late_reg;

	// First stage feeds only the second, to contain metastability
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			meta_reg <= IDLE;
			mid_reg <= IDLE;
			late_reg <= IDLE;
		end
		else
		begin
			meta_reg <= pin_i;
			mid_reg <= meta_reg;
			late_reg <= mid_reg;
		end
	end

	// Level moves only once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			level_o <= IDLE;
		else if (mid_reg == late_reg)
			level_o <= late_reg;
	end

endmodule
`default_nettype wire

// ### core/ipcr_quarter_tick.sv
`timescale 1ns/100ps
`default_nettype none
// Quarter bit-period strobe: one pulse every reload+1 cycles
module ipcr_quarter_tick #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control
	input wire logic run_i,
	input wire logic [CNT_W-1:0] reload_i,
	// Strobe
	output logic tick_o
);

	if (CNT_W < 1)
	begin : g_bad_width
		$error("ipcr_quarter_tick: CNT_W must be at least 1");
	end

	logic [CNT_W-1:0] count_reg;

	// Counter restarts whenever the sequencer is idle
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || !run_i)
		begin
			count_reg <= '0;
			tick_o <= 1'b0;
		end
		else if (count_reg == reload_i)
		begin
			count_reg <= '0;
			tick_o <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + 1'b1;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### core/ipcr_core.sv
//Behaviour
//- Master transmit: buffer write while master busy sets write collision flag.
//- Slave transmit: buffer write while still shifting sets write collision flag.
//- Write collision flag is meaningless while receiving.
//- Receive: byte arriving while buffer full sets overflow flag until software clears.
//- Overflow flag is meaningless while transmitting.
//- Port enable hands pins to the port; cleared, pins become general I/O.
//- Slave holds clock low while release bit is 0, releases at 1.
//- Master ignores the clock-release bit.
//- Modes 0110 and 0111 are 7- and 10-bit slave, no start/stop events.
//- Modes 1110 and 1111 are slave modes that also flag start and stop.
//- 1000 is hardware master, quarter period reload+1; 1011 enables neither master nor slave.
//- Repeated start request makes a repeated start, then clears itself.
//- Start request makes a start condition, then clears itself.
//- Slave with stretch bit holds clock after a received byte while the buffer is still full.
//- Slave withholds ack and keeps buffer when full or overflowed.
`timescale 1ns/100ps
`default_nettype none
module ipcr_core
	import ipcr_pkg::*;
#(
	parameter int ADDR_W = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Bus clock pin
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	// Bus data pin
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Sticky port event flag
	output logic event_o
);

	if (ADDR_W < 3)
	begin : g_bad_addr
		$error("ipcr_core: ADDR_W must be at least 3");
	end

	typedef enum {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} ipcr_mstate_t;

	ipcr_ctrl_primary_t c1_reg;
	ipcr_ctrl_secondary_t c2_reg;
	ipcr_mstate_t m_state_reg;
	logic [7:0] buf_reg, reload_reg, sr_reg;
	logic [1:0] gpio_out_reg, gpio_dir_reg, q_reg;
	logic [3:0] m_bit_reg, s_cnt_reg;
	logic buf_full_reg, addr_update_reg, rw_reg, start_seen_reg, stop_seen_reg;
	logic scl_s, sda_s, scl_d_reg, sda_d_reg, tick;
	logic m_hold_reg;
	logic s_listen_reg, s_active_reg, s_tx_reg, s_hi10_reg, s_ack_reg, s_txbit_reg;

	// Pin inputs cross into the clock domain
	ipcr_pin_sync #(.IDLE(1'b1)) u_scl_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.pin_i(scl_i),
		.level_o(scl_s)
	);
	ipcr_pin_sync #(.IDLE(1'b1)) u_sda_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.pin_i(sda_i),
		.level_o(sda_s)
	);

	// Quarter-period strobe for the master sequencer
	ipcr_quarter_tick #(.CNT_W(8)) u_tick (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(m_state_reg != M_IDLE),
		.reload_i(reload_reg),
		.tick_o(tick)
	);

	// Mode decode; unlisted encodings leave both engines idle
	logic is_master, is_slave, ten_bit, ss_events;
	always_comb
	begin
		is_master = c1_reg.port_enable_bit && (c1_reg.mode_select_field == MODE_MASTER);
		is_slave = c1_reg.port_enable_bit && (c1_reg.mode_select_field inside
			{MODE_SLAVE7, MODE_SLAVE10, MODE_SLAVE7_EVT, MODE_SLAVE10_EVT});
		ten_bit = c1_reg.mode_select_field[0];
		ss_events = c1_reg.mode_select_field[3];
	end

	// Register strobes
	logic wr_c1, wr_c2, wr_buf, rd_buf, wr_reload, wr_status, wr_gpio;
	always_comb
	begin
		wr_c1 = wr_i && (addr_i == ADDR_W'(ADDR_CTRL_PRIMARY));
		wr_c2 = wr_i && (addr_i == ADDR_W'(ADDR_CTRL_SECONDARY));
		wr_buf = wr_i && (addr_i == ADDR_W'(ADDR_TRANSFER_BUFFER));
		rd_buf = rd_i && (addr_i == ADDR_W'(ADDR_TRANSFER_BUFFER));
		wr_reload = wr_i && (addr_i == ADDR_W'(ADDR_RELOAD));
		wr_status = wr_i && (addr_i == ADDR_W'(ADDR_STATUS));
		wr_gpio = wr_i && (addr_i == ADDR_W'(ADDR_GPIO));
	end

	// Master sequencer timing: a bit holds on a stretched clock before sampling
	logic adv, m_last, m_done, m_free, m_scl, m_sda;
	always_comb
	begin
		adv = tick && !(q_reg == 2'h1 && !scl_s);
		case (m_state_reg)
			M_TX: m_last = (m_bit_reg == BITS_PER_BYTE);
			M_RX: m_last = (m_bit_reg == BITS_PER_BYTE - 4'h1);
			default: m_last = 1'b1;
		endcase
		m_done = adv && (q_reg == QUARTER_LAST) && m_last;
		m_free = (m_state_reg == M_IDLE) && !c2_reg.start_or_stretch_bit
			&& !c2_reg.repeated_start_request && !c2_reg.stop_request
			&& !c2_reg.master_receive_request && !c2_reg.ack_sequence_request;
	end

	// Line levels per quarter (1 means released)
	always_comb
	begin
		m_scl = (q_reg == 2'h1) || (q_reg == 2'h2);
		m_sda = 1'b1;
		case (m_state_reg)
			M_START:
			begin
				m_scl = (q_reg < 2'h2);
				m_sda = (q_reg == 2'h0);
			end
			M_RSTART:
				m_sda = (q_reg < 2'h2);
			M_STOP:
			begin
				m_scl = (q_reg != 2'h0);
				m_sda = (q_reg >= 2'h2);
			end
			M_TX:
				m_sda = (m_bit_reg == BITS_PER_BYTE) || sr_reg[7];
			M_ACK:
				m_sda = c2_reg.ack_data_value;
			M_RX:
				m_sda = 1'b1;
			default:
			begin
				// Clock stays low between sequences until a stop, so no stray stop appears
				m_scl = !m_hold_reg;
				m_sda = 1'b1;
			end
		endcase
	end

	// Master state
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || !is_master)
		begin
			m_state_reg <= M_IDLE;
			q_reg <= 2'h0;
			m_bit_reg <= 4'h0;
		end
		else if (m_state_reg == M_IDLE)
		begin
			q_reg <= 2'h0;
			m_bit_reg <= 4'h0;
			if (c2_reg.start_or_stretch_bit)
				m_state_reg <= M_START;
			else if (c2_reg.repeated_start_request)
				m_state_reg <= M_RSTART;
			else if (c2_reg.stop_request)
				m_state_reg <= M_STOP;
			else if (c2_reg.master_receive_request)
				m_state_reg <= M_RX;
			else if (c2_reg.ack_sequence_request)
				m_state_reg <= M_ACK;
			else if (wr_buf)
				m_state_reg <= M_TX;
		end
		else if (adv)
		begin
			q_reg <= q_reg + 2'h1;
			if (q_reg == QUARTER_LAST)
				m_bit_reg <= m_bit_reg + 4'h1;
			if (m_done)
				m_state_reg <= M_IDLE;
		end
	end

	// Bus stays claimed after each sequence until a stop completes
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || !is_master)
			m_hold_reg <= 1'b0;
		else if (m_done)
			m_hold_reg <= (m_state_reg != M_STOP);
	end

	// Slave bus events from filtered pins
	logic scl_rise, scl_fall, bus_start, bus_stop, hdr_hit, addr_hit;
	logic s_rx_byte, s_accept, s_load, s_end9, ckp_hold;
	always_comb
	begin
		scl_rise = scl_s && !scl_d_reg;
		scl_fall = !scl_s && scl_d_reg;
		bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
		bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;
		hdr_hit = (sr_reg[7:3] == TEN_BIT_HEADER) && (sr_reg[2:1] == reload_reg[2:1]);
		if (ten_bit && s_hi10_reg)
			addr_hit = (sr_reg == reload_reg);
		else if (ten_bit)
			addr_hit = hdr_hit;
		else
			addr_hit = (sr_reg[7:1] == reload_reg[7:1])
				|| (c2_reg.general_call_enable && sr_reg == GENERAL_CALL_ADDR);
		s_rx_byte = is_slave && scl_fall && (s_cnt_reg == BITS_PER_BYTE)
			&& (s_listen_reg || (s_active_reg && !s_tx_reg));
		s_accept = s_rx_byte && (s_active_reg || addr_hit);
		s_load = s_accept && !buf_full_reg && !c1_reg.receive_overflow_flag;
		s_end9 = is_slave && scl_fall && (s_cnt_reg == ACK_SLOT) && s_active_reg;
		ckp_hold = s_end9 && (s_tx_reg || (c2_reg.start_or_stretch_bit && buf_full_reg));
	end

	// Slave engine
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || !is_slave)
		begin
			s_listen_reg <= 1'b0;
			s_active_reg <= 1'b0;
			s_tx_reg <= 1'b0;
			s_hi10_reg <= 1'b0;
			s_cnt_reg <= 4'h0;
			s_ack_reg <= 1'b0;
			s_txbit_reg <= 1'b1;
		end
		else if (bus_start || bus_stop)
		begin
			s_listen_reg <= bus_start;
			s_active_reg <= 1'b0;
			s_tx_reg <= 1'b0;
			s_hi10_reg <= s_hi10_reg && bus_start;
			s_cnt_reg <= 4'h0;
			s_ack_reg <= 1'b0;
			s_txbit_reg <= 1'b1;
		end
		else
		begin
			if (scl_rise && s_cnt_reg < BITS_PER_BYTE && (s_listen_reg || s_active_reg))
				s_cnt_reg <= s_cnt_reg + 4'h1;
			// A high data line at a rise while the count is eight ends the read; the nack rise sees nine
			if (scl_rise && s_cnt_reg == BITS_PER_BYTE && s_tx_reg && sda_s)
			begin
				s_active_reg <= 1'b0;
				s_tx_reg <= 1'b0;
			end
			if (s_rx_byte)
			begin
				s_cnt_reg <= ACK_SLOT;
				s_ack_reg <= s_load;
				if (s_accept && !s_active_reg)
				begin
					if (ten_bit && !s_hi10_reg && !sr_reg[0])
						s_hi10_reg <= 1'b1;
					else
					begin
						s_active_reg <= 1'b1;
						s_listen_reg <= 1'b0;
						s_hi10_reg <= 1'b0;
						s_tx_reg <= sr_reg[0];
					end
				end
			end
			if (scl_fall && s_tx_reg && s_cnt_reg == BITS_PER_BYTE)
				s_cnt_reg <= ACK_SLOT;
			if (scl_fall && s_cnt_reg == ACK_SLOT)
			begin
				s_cnt_reg <= 4'h0;
				s_ack_reg <= 1'b0;
				if (!s_active_reg && !s_hi10_reg)
					s_listen_reg <= 1'b0;
			end
			// Transmit bits change at a clock fall or on any buffer write, colliding or not
			if (wr_buf && s_tx_reg)
				s_txbit_reg <= wdata_i[7];
			else if (scl_fall && s_tx_reg)
			begin
				if (s_cnt_reg < BITS_PER_BYTE)
					s_txbit_reg <= sr_reg[3'(4'h7 - s_cnt_reg)];
				else
					s_txbit_reg <= (s_cnt_reg == ACK_SLOT) ? sr_reg[7] : 1'b1;
			end
		end
	end

	// Pin history for edge detection
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Flag events
	logic m_rx_end, write_collision_flag_set, ov_set, bf_set, bf_clr, evt_set;
	always_comb
	begin
		m_rx_end = m_done && (m_state_reg == M_RX);
		write_collision_flag_set = wr_buf && ((is_master && !m_free)
			|| (is_slave && s_tx_reg && c1_reg.clock_release_bit));
		ov_set = (s_accept && buf_full_reg) || (m_rx_end && buf_full_reg);
		bf_set = s_load || (m_rx_end && !buf_full_reg) || (wr_buf && !write_collision_flag_set);
		bf_clr = (rd_buf && !s_tx_reg && m_state_reg != M_TX)
			|| (m_done && m_state_reg == M_TX)
			|| (is_slave && scl_fall && s_tx_reg && s_cnt_reg == BITS_PER_BYTE);
		evt_set = s_end9 || m_done || (is_slave && ss_events && (bus_start || bus_stop));
	end

	// First control register; hardware sets win over software clears
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			c1_reg <= ipcr_ctrl_primary_t'(CTRL_PRIMARY_RESET);
		else
		begin
			if (wr_c1)
				c1_reg <= ipcr_ctrl_primary_t'(wdata_i);
			else if (ckp_hold)
				c1_reg.clock_release_bit <= 1'b0;
			if (write_collision_flag_set)
				c1_reg.write_collision_flag <= 1'b1;
			if (ov_set)
				c1_reg.receive_overflow_flag <= 1'b1;
		end
	end

	// Second control register: one request at a time, only when idle
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			c2_reg <= ipcr_ctrl_secondary_t'(CTRL_SECONDARY_RESET);
		else
		begin
			if (m_done && m_state_reg == M_TX)
				c2_reg.ack_received_status <= sda_s;
			if (m_done)
			begin
				c2_reg.start_or_stretch_bit <= 1'b0;
				c2_reg.repeated_start_request <= 1'b0;
				c2_reg.stop_request <= 1'b0;
				c2_reg.master_receive_request <= 1'b0;
				c2_reg.ack_sequence_request <= 1'b0;
			end
			if (wr_c2)
			begin
				c2_reg.general_call_enable <= wdata_i[7];
				c2_reg.ack_data_value <= wdata_i[5];
				if (!is_master)
					c2_reg.start_or_stretch_bit <= wdata_i[0];
				else if (m_free)
				begin
					c2_reg.start_or_stretch_bit <= wdata_i[0];
					c2_reg.repeated_start_request <= wdata_i[1] && !wdata_i[0];
					c2_reg.stop_request <= wdata_i[2] && (wdata_i[1:0] == 2'h0);
					c2_reg.master_receive_request <= wdata_i[3] && (wdata_i[2:0] == 3'h0);
					c2_reg.ack_sequence_request <= wdata_i[4] && (wdata_i[3:0] == 4'h0);
				end
			end
		end
	end

	// Shift register, buffer and reload value
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sr_reg <= BUFFER_RESET;
			buf_reg <= BUFFER_RESET;
			reload_reg <= RELOAD_RESET;
		end
		else
		begin
			// A colliding write is dropped here, so buf_reg and sr_reg keep the byte in flight
			if (wr_buf && !write_collision_flag_set)
			begin
				buf_reg <= wdata_i;
				sr_reg <= wdata_i;
			end
			else if (m_state_reg == M_RX && adv && q_reg == 2'h2)
				sr_reg <= {sr_reg[6:0], sda_s};
			else if (m_state_reg == M_TX && adv && q_reg == QUARTER_LAST)
				sr_reg <= {sr_reg[6:0], 1'b1};
			else if (is_slave && scl_rise && s_cnt_reg < BITS_PER_BYTE && !s_tx_reg
				&& (s_listen_reg || s_active_reg))
				sr_reg <= {sr_reg[6:0], sda_s};
			if (s_load || (m_rx_end && !buf_full_reg))
				buf_reg <= sr_reg;
			if (wr_reload)
				reload_reg <= wdata_i;
		end
	end

	// Status bits
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			buf_full_reg <= 1'b0;
			addr_update_reg <= 1'b0;
			rw_reg <= 1'b0;
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
			event_o <= 1'b0;
		end
		else
		begin
			if (bf_set)
				buf_full_reg <= 1'b1;
			else if (bf_clr)
				buf_full_reg <= 1'b0;
			if (s_accept && ten_bit && !s_active_reg)
				addr_update_reg <= 1'b1;
			else if (wr_reload)
				addr_update_reg <= 1'b0;
			if (s_accept && !s_active_reg)
				rw_reg <= sr_reg[0];
			if (bus_start || bus_stop)
			begin
				start_seen_reg <= bus_start;
				stop_seen_reg <= bus_stop;
			end
			// Event flag clears by writing one; a new event wins
			if (evt_set)
				event_o <= 1'b1;
			else if (wr_status && wdata_i[ST_PORT_EVENT])
				event_o <= 1'b0;
		end
	end

	// General-purpose pin register
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			gpio_out_reg <= GPIO_RESET;
			gpio_dir_reg <= GPIO_RESET;
		end
		else if (wr_gpio)
		begin
			gpio_out_reg <= wdata_i[GPIO_OUT_LSB +: 2];
			gpio_dir_reg <= wdata_i[GPIO_DIR_LSB +: 2];
		end
	end

	// Pin drivers; open-drain lines only ever pull low when enabled
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else if (!c1_reg.port_enable_bit)
		begin
			scl_o <= gpio_out_reg[0];
			sda_o <= gpio_out_reg[1];
			scl_oe_o <= gpio_dir_reg[0];
			sda_oe_o <= gpio_dir_reg[1];
		end
		else
		begin
			// Direction register is not consulted here; software keeps it sane
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			if (is_master)
			begin
				scl_oe_o <= !m_scl;
				sda_oe_o <= !m_sda;
			end
			else
			begin
				scl_oe_o <= is_slave && !c1_reg.clock_release_bit;
				sda_oe_o <= is_slave && (s_ack_reg
					|| (s_tx_reg && s_cnt_reg != ACK_SLOT && !s_txbit_reg));
			end
		end
	end

	// Registered read port; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || !rd_i)
			rdata_o <= 8'h00;
		else
		begin
			case (addr_i)
				ADDR_W'(ADDR_CTRL_PRIMARY): rdata_o <= c1_reg;
				ADDR_W'(ADDR_CTRL_SECONDARY): rdata_o <= c2_reg;
				ADDR_W'(ADDR_TRANSFER_BUFFER): rdata_o <= buf_reg;
				ADDR_W'(ADDR_RELOAD): rdata_o <= reload_reg;
				ADDR_W'(ADDR_STATUS): rdata_o <= {2'h0, event_o, stop_seen_reg,
					start_seen_reg, rw_reg, addr_update_reg, buf_full_reg};
				ADDR_W'(ADDR_GPIO): rdata_o <= {2'h0, sda_s, scl_s, gpio_dir_reg, gpio_out_reg};
				default: rdata_o <= 8'h00;
			endcase
		end
	end

endmodule
`default_nettype wire

// ### test/ipcr_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks for the two-wire control block
module ipcr_chk
	import ipcr_pkg::*;
#(
	parameter int ADDR_W = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Pins and event
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic event_o
);
	logic en_reg;
	logic mst_reg;
	logic oe_reg;
	logic [7:0] rl_reg;
	logic [7:0] run_reg;
	logic w1;
	logic w2;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Strobe decodes
	assign w1 = wr_i && addr_i == ADDR_W'(0);
	assign w2 = wr_i && addr_i == ADDR_W'(1);
	// Software view of enable, master mode and reload
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			en_reg <= 1'b0;
			mst_reg <= 1'b0;
			rl_reg <= 8'h00;
		end
		else
		begin
			if (w1)
			begin
				en_reg <= wdata_i[5];
				mst_reg <= wdata_i[5] && wdata_i[3:0] == MODE_MASTER;
			end
			if (wr_i && addr_i == ADDR_W'(3))
				rl_reg <= wdata_i;
		end
	end
	// Cycles since clock drive changed; saturates so idle never wraps
	always_ff @(posedge clk_i)
	begin
		oe_reg <= scl_oe_o;
		if (!resetn_i || scl_oe_o != oe_reg)
			run_reg <= 8'h00;
		else if (run_reg != 8'hFF)
			run_reg <= run_reg + 8'h01;
	end
	a_read_gap: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	a_unmapped_read: assert property (rd_i && addr_i > ADDR_W'(5) |=> rdata_o == 8'h00)
		else $error("unmapped index returned data");
	a_mode_readback: assert property ((w1 ##2 (rd_i && addr_i == ADDR_W'(0)))
		|=> rdata_o[5:0] == $past(wdata_i[5:0], 3)) else $error("mode field lost");
	a_open_drain: assert property (en_reg && $past(en_reg) |-> !scl_o && !sda_o)
		else $error("enabled port drives a pin high");
	a_slave_hold: assert property (w1 && wdata_i[5:0] == 6'h26 |-> ##[1:3] scl_oe_o)
		else $error("slave did not hold clock");
	a_slave_free: assert property (w1 && wdata_i[5:0] == 6'h36 |-> ##3 !scl_oe_o[*2])
		else $error("slave kept clock held");
	a_master_ignore: assert property (!mst_reg && w1 && wdata_i[5:0] == 6'h28
		|-> ##3 !scl_oe_o[*2]) else $error("master obeyed release bit");
	a_start_shape: assert property (mst_reg && w2 && wdata_i inside {8'h01, 8'h02}
		|-> ##[2:80] (sda_oe_o && !scl_oe_o)) else $error("no start shape");
	a_master_pace: assert property (mst_reg && $changed(scl_oe_o) |-> run_reg >= rl_reg)
		else $error("clock edge faster than quarter");
endmodule
bind ipcr_core ipcr_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .event_o(event_o));
`default_nettype wire

// ### test/ipcr_bus_peer.sv
`timescale 1ns/100ps
`default_nettype none
// Far-side device: pull-ups, acknowledge and optional clock stretch
module ipcr_bus_peer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Behaviour controls
	input wire logic ack_i,
	input wire logic slow_i,
	// Design pin drivers
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Resolved wires
	output logic scl_w,
	output logic sda_w
);
	logic [3:0] falls_reg;
	logic [2:0] hold_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	// Open drain: released lines float to the pull-up level
	assign scl_w = !(scl_oe_o && !scl_o) && hold_reg == 3'h0;
	// The fall after a start counts one, so the ninth bit follows fall nine
	assign sda_w = !(sda_oe_o && !sda_o) && !(ack_i && falls_reg == 4'h9);
	// Count clock falls; start or stop restarts the frame
	always_ff @(posedge clk_i)
	begin
		scl_d_reg <= scl_w;
		sda_d_reg <= sda_w;
		if (!resetn_i || (scl_w && scl_d_reg && sda_w != sda_d_reg))
			falls_reg <= 4'h0;
		else if (scl_d_reg && !scl_w)
			falls_reg <= falls_reg == 4'h9 ? 4'h1 : falls_reg + 4'h1;
	end
	// Slow answer: keep the clock low a while after each fall
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			hold_reg <= 3'h0;
		else if (scl_d_reg && !scl_w && slow_i)
			hold_reg <= 3'h6;
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
	end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the two-wire control block
module tb
	import ipcr_pkg::*;
;
	localparam logic [2:0] C1 = ADDR_CTRL_PRIMARY;
	localparam logic [2:0] C2 = ADDR_CTRL_SECONDARY;
	logic [3:0] modes [6] = '{MODE_SLAVE7, MODE_SLAVE10, MODE_MASTER, MODE_FW_MASTER,
		MODE_SLAVE7_EVT, MODE_SLAVE10_EVT};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic ack = 1'b1;
	logic slow = 1'b0;
	logic [7:0] rdata;
	logic scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w, ev;
	logic [8:0] sh = 9'h000;
	logic [7:0] v, d;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	ipcr_core dut_u (.clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .event_o(ev));
	ipcr_bus_peer peer_u (.clk_i(clk), .resetn_i(resetn), .ack_i(ack), .slow_i(slow),
		.scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.scl_w(scl_w), .sda_w(sda_w));
	task automatic end_of_test();
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Gap cycle after each strobe so no signal is set twice in one step
	task automatic wr(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		x = rdata;
	endtask
	// Poll until the masked bits drop, bounded
	task automatic wait_clear(input logic [2:0] a, input logic [7:0] m);
		int k;
		k = 0;
		v = m;
		while ((v & m) != 8'h00 && k < 300)
		begin
			rd(a, v);
			k++;
		end
		chk(v & m, 8'h00);
	endtask
	task automatic pins(input logic [7:0] e);
		repeat (3) @(negedge clk);
		chk({6'h00, scl_oe, sda_oe}, e);
	endtask
	// Clock, wire monitor and hang guard
	always #25 clk = ~clk;
	always @(posedge scl_w) sh <= {sh[7:0], sda_w};
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	initial
	begin
		void'($urandom(32'h4d6c4e9a));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd(C1, v);
		chk(v, CTRL_PRIMARY_RESET);
		rd(C2, v);
		chk(v, CTRL_SECONDARY_RESET);
		rd(3'h6, v);
		chk(v, 8'h00);
		// Each listed mode with the port off
		foreach (modes[i])
		begin
			d = {3'h0, 1'($urandom_range(1, 0)), modes[i]};
			wr(C1, d);
			rd(C1, v);
			chk(v, d);
		end
		wr(ADDR_GPIO, 8'h04);
		pins(8'h02);
		wr(ADDR_GPIO, 8'h00);
		wr(C1, 8'h26);
		pins(8'h02);
		wr(C1, 8'h36);
		pins(8'h00);
		// Master at a random rate; a stop behind the start is dropped
		wr(ADDR_RELOAD, 8'($urandom_range(3, 2)));
		wr(C1, 8'h28);
		pins(8'h00);
		wr(ADDR_STATUS, 8'h20);
		wr(C2, 8'h01);
		wr(C2, 8'h04);
		rd(C2, v);
		chk(v & 8'h05, 8'h01);
		wait_clear(C2, 8'h01);
		chk({7'h00, ev}, 8'h01);
		// Byte out to a slow peer; the second write collides
		d = 8'($urandom());
		slow <= 1'b1;
		wr(ADDR_TRANSFER_BUFFER, d);
		wr(ADDR_TRANSFER_BUFFER, ~d);
		rd(C1, v);
		chk(v, 8'hA8);
		wr(C1, 8'h28);
		wait_clear(ADDR_STATUS, 8'h01);
		chk(sh[8:1], d);
		rd(C2, v);
		chk(v, 8'h00);
		// Two bytes in without a read: the second overflows
		ack <= 1'b0;
		repeat (2)
		begin
			wr(C2, 8'h08);
			wait_clear(C2, 8'h08);
		end
		rd(C1, v);
		chk(v & 8'h7F, 8'h68);
		rd(ADDR_TRANSFER_BUFFER, v);
		chk(v, 8'hFF);
		wr(C2, 8'h30);
		wait_clear(C2, 8'h10);
		chk({7'h00, sh[0]}, 8'h01);
		wr(C2, 8'h02);
		wait_clear(C2, 8'h02);
		wr(C2, 8'h04);
		wait_clear(C2, 8'h04);
		repeat (8) @(negedge clk);
		chk({6'h00, scl_w, sda_w}, 8'h03);
		end_of_test();
	end
endmodule
`default_nettype wire
